// file: hdl/reset_cause_initialiser.sv
// reset-cause initialiser: cause detection, reset flags, watchdog and reset table
//
// How it works
// - normal watchdog reset equals low-voltage reset
// - halt watchdog clears only counter and stack
// - flags in status, power-on clears both
// - low-voltage reset leaves both flags alone
// - normal watchdog sets timeout, keeps power-down
// - halt watchdog sets both flags
// - power-on disables all interrupts
// - power-on clears watchdog, counting resumes
// - power-on switches all timers off
// - power-on makes every pin input
// - power-on zeroes counter, stack at top
// - per-cause table loads each register
// - halt watchdog keeps registers, counter low zero
// - watchdog control reloads except halt watchdog
// - low-voltage reset sets its clear-only flag
// - bad enable code resets after slow cycles
//
// Local design decisions: the register offsets and strobed register access.
module reset_cause_initialiser (
  // clock and power-on reset
  input wire logic clk,
  input wire logic rst_b,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] rdata_q,
  // processor core
  input wire logic core_halt,
  input wire logic wdt_clear_cmd,
  input wire logic [2:0] sfr_index,
  output reset_cause_pkg::reset_effects_type effects_q,
  output reset_cause_pkg::cause_type cause_q,
  output reset_cause_pkg::sfr_init_type sfr_init_q,
  // pins from the analog side
  input wire logic low_speed_internal_oscillator_clk_in,
  input wire logic lvr_detect_in,
  // interrupt
  output logic irq_q
);

  ////////////////////////////////////////////////////////////////////////////
  // functions

  function automatic logic [15:0] wdt_limit(input logic [2:0] sel);
    logic [15:0] one;
    one = 16'h0001;
    wdt_limit = (one << (reset_cause_pkg::wdt_base_exp + sel)) - one;
  endfunction : wdt_limit

  function automatic reset_cause_pkg::reset_effects_type effects_of(
      input reset_cause_pkg::cause_type cause);
    reset_cause_pkg::reset_effects_type e;
    e = '0;
    case (cause)
      reset_cause_pkg::cause_wdt_halt: begin
        e.pc_zero = 1'b1;
        e.sp_zero = 1'b1;
      end
      reset_cause_pkg::cause_none: begin
        e = '0;
      end
      default: begin
        e = '1;
        e.sp_zero = 1'b0;
      end
    endcase
    effects_of = e;
  endfunction : effects_of

  function automatic reset_cause_pkg::sfr_init_type sfr_entry(
      input reset_cause_pkg::cause_type cause, input logic [2:0] idx);
    reset_cause_pkg::sfr_init_type s;
    s.value = reset_cause_pkg::zero_reset;
    s.keep = reset_cause_pkg::keep_none;
    if (cause == reset_cause_pkg::cause_none) begin
      s.keep = reset_cause_pkg::keep_all;
    end else if (cause == reset_cause_pkg::cause_wdt_halt) begin
      s.keep = reset_cause_pkg::keep_all;
      if (idx == reset_cause_pkg::sfr_pc_low) begin
        s.keep = reset_cause_pkg::keep_none;
      end else if (idx == reset_cause_pkg::sfr_status) begin
        s.value = reset_cause_pkg::status_wdt_halt_value;
        s.keep = reset_cause_pkg::status_wdt_halt_keep;
      end
    end else begin
      case (idx)
        reset_cause_pkg::sfr_status: begin
          if (cause == reset_cause_pkg::cause_wdt_run) begin
            s.value = reset_cause_pkg::status_wdt_run_value;
            s.keep = reset_cause_pkg::status_wdt_run_keep;
          end else if (cause != reset_cause_pkg::cause_por) begin
            s.keep = reset_cause_pkg::keep_all;
          end
        end
        reset_cause_pkg::sfr_mode: s.value = reset_cause_pkg::mode_reset;
        reset_cause_pkg::sfr_port_a: s.value = reset_cause_pkg::port_reset;
        reset_cause_pkg::sfr_port_a_dir: s.value = reset_cause_pkg::port_reset;
        reset_cause_pkg::sfr_wdt_ctrl: s.value = reset_cause_pkg::wdt_ctrl_reset;
        reset_cause_pkg::sfr_time_base: s.value = reset_cause_pkg::time_base_reset;
        default: s.value = reset_cause_pkg::zero_reset;
      endcase
    end
    sfr_entry = s;
  endfunction : sfr_entry

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic low_speed_internal_oscillator_s1_q, low_speed_internal_oscillator_s2_q, low_speed_internal_oscillator_s3_q, low_speed_internal_oscillator_level_q;
  logic lvr_s1_q, lvr_s2_q, lvr_s3_q, lvr_level_q;
  logic low_speed_internal_oscillator_tick;
  logic lvr_rise;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      low_speed_internal_oscillator_s1_q <= 1'b0;
      low_speed_internal_oscillator_s2_q <= 1'b0;
      low_speed_internal_oscillator_s3_q <= 1'b0;
      low_speed_internal_oscillator_level_q <= 1'b0;
      lvr_s1_q <= 1'b0;
      lvr_s2_q <= 1'b0;
      lvr_s3_q <= 1'b0;
      lvr_level_q <= 1'b0;
    end else begin
      low_speed_internal_oscillator_s1_q <= low_speed_internal_oscillator_clk_in;
      low_speed_internal_oscillator_s2_q <= low_speed_internal_oscillator_s1_q;
      low_speed_internal_oscillator_s3_q <= low_speed_internal_oscillator_s2_q;
      if (low_speed_internal_oscillator_s2_q == low_speed_internal_oscillator_s3_q) begin
        low_speed_internal_oscillator_level_q <= low_speed_internal_oscillator_s3_q;
      end
      lvr_s1_q <= lvr_detect_in;
      lvr_s2_q <= lvr_s1_q;
      lvr_s3_q <= lvr_s2_q;
      if (lvr_s2_q == lvr_s3_q) begin
        lvr_level_q <= lvr_s3_q;
      end
    end
  end

  assign low_speed_internal_oscillator_tick = (low_speed_internal_oscillator_s2_q == low_speed_internal_oscillator_s3_q) && low_speed_internal_oscillator_s3_q && !low_speed_internal_oscillator_level_q;
  assign lvr_rise = (lvr_s2_q == lvr_s3_q) && lvr_s3_q && !lvr_level_q;

  ////////////////////////////////////////////////////////////////////////////
  // cause selection

  logic por_done_q;
  reset_cause_pkg::delay_state_type delay_q;
  logic pend_lvr_q, pend_wdt_reg_q;
  logic [15:0] wdt_cnt_q;
  logic [7:0] wdt_ctrl_q;
  logic halt_seen_q;
  logic wdt_expired;
  logic delay_fire;
  logic bad_enable_write;
  logic wdt_ctrl_wr;
  reset_cause_pkg::cause_type cause;
  reset_cause_pkg::reset_effects_type effects;
  logic full_reset;

  assign wdt_ctrl_wr = reg_wr && (reg_addr == reset_cause_pkg::addr_wdt_ctrl);
  assign bad_enable_write = wdt_ctrl_wr
      && (reg_wdata[reset_cause_pkg::wdt_enable_msb:reset_cause_pkg::wdt_enable_lsb]
          != reset_cause_pkg::wdt_enable_code_a)
      && (reg_wdata[reset_cause_pkg::wdt_enable_msb:reset_cause_pkg::wdt_enable_lsb]
          != reset_cause_pkg::wdt_enable_code_b);
  assign wdt_expired = low_speed_internal_oscillator_tick
      && (wdt_cnt_q == wdt_limit(wdt_ctrl_q[reset_cause_pkg::wdt_sel_msb:0]));
  assign delay_fire = low_speed_internal_oscillator_tick && (delay_q == reset_cause_pkg::st_wait3);

  always_comb begin
    if (!por_done_q) begin
      cause = reset_cause_pkg::cause_por;
    end else if (delay_fire && pend_lvr_q && !core_halt) begin
      cause = reset_cause_pkg::cause_lvr;
    end else if (delay_fire && pend_wdt_reg_q) begin
      cause = reset_cause_pkg::cause_wdt_reg;
    end else if (wdt_expired) begin
      cause = core_halt ? reset_cause_pkg::cause_wdt_halt : reset_cause_pkg::cause_wdt_run;
    end else begin
      cause = reset_cause_pkg::cause_none;
    end
  end

  assign effects = effects_of(cause);
  assign full_reset = effects.sfr_load;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      por_done_q <= 1'b0;
    end else begin
      por_done_q <= 1'b1;
    end
  end

  // slow-clock delay; low-voltage detect also waits here
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      delay_q <= reset_cause_pkg::st_run;
      pend_lvr_q <= 1'b0;
      pend_wdt_reg_q <= 1'b0;
    end else if (full_reset) begin
      delay_q <= reset_cause_pkg::st_run;
      pend_lvr_q <= 1'b0;
      pend_wdt_reg_q <= 1'b0;
    end else begin
      // low-voltage sensing is off while halted
      if (lvr_rise && !core_halt) begin
        pend_lvr_q <= 1'b1;
      end
      if (bad_enable_write) begin
        pend_wdt_reg_q <= 1'b1;
      end
      case (delay_q)
        reset_cause_pkg::st_run: begin
          if ((lvr_rise && !core_halt) || bad_enable_write) begin
            delay_q <= reset_cause_pkg::st_wait1;
          end
        end
        reset_cause_pkg::st_wait1: begin
          if (low_speed_internal_oscillator_tick) begin
            delay_q <= reset_cause_pkg::st_wait2;
          end
        end
        reset_cause_pkg::st_wait2: begin
          if (low_speed_internal_oscillator_tick) begin
            delay_q <= reset_cause_pkg::st_wait3;
          end
        end
        reset_cause_pkg::st_wait3: begin
          if (low_speed_internal_oscillator_tick) begin
            delay_q <= reset_cause_pkg::st_run;
            pend_lvr_q <= 1'b0;
          end
        end
        default: delay_q <= reset_cause_pkg::st_run;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // watchdog counter

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wdt_cnt_q <= 16'h0000;
      halt_seen_q <= 1'b0;
    end else begin
      halt_seen_q <= core_halt;
      if (effects.wdt_clear || wdt_expired || wdt_clear_cmd || (core_halt && !halt_seen_q)) begin
        wdt_cnt_q <= 16'h0000;
      end else if (low_speed_internal_oscillator_tick) begin
        wdt_cnt_q <= wdt_cnt_q + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset flags

  logic timeout_flag_q, power_down_flag_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      timeout_flag_q <= 1'b0;
      power_down_flag_q <= 1'b0;
    end else begin
      if (core_halt && !halt_seen_q) begin
        timeout_flag_q <= 1'b0;
        power_down_flag_q <= 1'b1;
      end
      if (wdt_clear_cmd) begin
        timeout_flag_q <= 1'b0;
        power_down_flag_q <= 1'b0;
      end
      // low-voltage and register resets leave flags
      case (cause)
        reset_cause_pkg::cause_por: begin
          timeout_flag_q <= 1'b0;
          power_down_flag_q <= 1'b0;
        end
        reset_cause_pkg::cause_wdt_run: begin
          timeout_flag_q <= 1'b1;
          power_down_flag_q <= power_down_flag_q;
        end
        reset_cause_pkg::cause_wdt_halt: begin
          timeout_flag_q <= 1'b1;
          power_down_flag_q <= 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // watchdog control and secondary mode register

  logic fsys_on_q, lvr_cause_q, wdt_reg_cause_q;
  logic mode2_wr;

  assign mode2_wr = reg_wr && (reg_addr == reset_cause_pkg::addr_mode2);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wdt_ctrl_q <= reset_cause_pkg::wdt_ctrl_reset;
    end else if (full_reset) begin
      wdt_ctrl_q <= reset_cause_pkg::wdt_ctrl_reset;
    end else if (wdt_ctrl_wr) begin
      wdt_ctrl_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fsys_on_q <= 1'b0;
      lvr_cause_q <= 1'b0;
      wdt_reg_cause_q <= 1'b0;
    end else begin
      if (full_reset) begin
        fsys_on_q <= 1'b0;
        wdt_reg_cause_q <= 1'b0;
        if (cause == reset_cause_pkg::cause_por) begin
          lvr_cause_q <= 1'b0;
        end
      end else if (mode2_wr) begin
        // software can only clear the cause flags
        fsys_on_q <= reg_wdata[reset_cause_pkg::fsys_on_bit];
        lvr_cause_q <= lvr_cause_q & reg_wdata[reset_cause_pkg::lvr_cause_bit];
        wdt_reg_cause_q <= wdt_reg_cause_q & reg_wdata[reset_cause_pkg::wdt_reg_cause_bit];
      end
      if (cause == reset_cause_pkg::cause_lvr) begin
        lvr_cause_q <= 1'b1;
      end
      if (cause == reset_cause_pkg::cause_wdt_reg) begin
        wdt_reg_cause_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status

  logic [reset_cause_pkg::irq_width-1:0] irq_status_q, irq_enable_q, irq_events;

  always_comb begin
    irq_events = '0;
    irq_events[reset_cause_pkg::irq_por_bit] = (cause == reset_cause_pkg::cause_por);
    irq_events[reset_cause_pkg::irq_lvr_bit] = (cause == reset_cause_pkg::cause_lvr);
    irq_events[reset_cause_pkg::irq_wdt_run_bit] = (cause == reset_cause_pkg::cause_wdt_run);
    irq_events[reset_cause_pkg::irq_wdt_halt_bit] = (cause == reset_cause_pkg::cause_wdt_halt);
    irq_events[reset_cause_pkg::irq_wdt_reg_bit] = (cause == reset_cause_pkg::cause_wdt_reg);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_status_q <= '0;
      irq_enable_q <= '0;
      irq_q <= 1'b0;
    end else begin
      if (reg_wr && (reg_addr == reset_cause_pkg::addr_irq_clear)) begin
        irq_status_q <= (irq_status_q & ~reg_wdata[reset_cause_pkg::irq_width-1:0]) | irq_events;
      end else begin
        irq_status_q <= irq_status_q | irq_events;
      end
      if (full_reset) begin
        irq_enable_q <= '0;
      end else if (reg_wr && (reg_addr == reset_cause_pkg::addr_irq_enable)) begin
        irq_enable_q <= reg_wdata[reset_cause_pkg::irq_width-1:0];
      end
      irq_q <= |(irq_status_q & irq_enable_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs to the core and read port

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      effects_q <= '0;
      cause_q <= reset_cause_pkg::cause_none;
      sfr_init_q <= '0;
    end else begin
      effects_q <= effects;
      if (cause != reset_cause_pkg::cause_none) begin
        cause_q <= cause;
      end
      sfr_init_q <= sfr_entry(cause_q, sfr_index);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      rdata_q <= 8'h00;
      case (reg_addr)
        reset_cause_pkg::addr_status: begin
          rdata_q[reset_cause_pkg::timeout_bit] <= timeout_flag_q;
          rdata_q[reset_cause_pkg::power_down_bit] <= power_down_flag_q;
        end
        reset_cause_pkg::addr_wdt_ctrl: rdata_q <= wdt_ctrl_q;
        reset_cause_pkg::addr_mode2: begin
          rdata_q[reset_cause_pkg::fsys_on_bit] <= fsys_on_q;
          rdata_q[reset_cause_pkg::lvr_cause_bit] <= lvr_cause_q;
          rdata_q[reset_cause_pkg::wdt_reg_cause_bit] <= wdt_reg_cause_q;
        end
        reset_cause_pkg::addr_irq_status: rdata_q[reset_cause_pkg::irq_width-1:0] <= irq_status_q;
        reset_cause_pkg::addr_irq_enable: rdata_q[reset_cause_pkg::irq_width-1:0] <= irq_enable_q;
        default: rdata_q <= 8'h00;
      endcase
    end
  end

endmodule : reset_cause_initialiser

// file: hdl/reset_cause_pkg.sv
// constants, cause codes and carrier types of the reset-cause initialiser
package reset_cause_pkg;

  // register port offsets
  localparam logic [3:0] addr_status = 4'h0;
  localparam logic [3:0] addr_wdt_ctrl = 4'h1;
  localparam logic [3:0] addr_mode2 = 4'h2;
  localparam logic [3:0] addr_irq_status = 4'h3;
  localparam logic [3:0] addr_irq_clear = 4'h4;
  localparam logic [3:0] addr_irq_enable = 4'h5;

  // field positions
  localparam int unsigned timeout_bit = 5;
  localparam int unsigned power_down_bit = 4;
  localparam int unsigned fsys_on_bit = 7;
  localparam int unsigned lvr_cause_bit = 2;
  localparam int unsigned wdt_reg_cause_bit = 0;
  localparam int unsigned wdt_enable_msb = 7;
  localparam int unsigned wdt_enable_lsb = 3;
  localparam int unsigned wdt_sel_msb = 2;

  // watchdog control codes and timing
  localparam logic [4:0] wdt_enable_code_a = 5'h0a;
  localparam logic [4:0] wdt_enable_code_b = 5'h15;
  localparam logic [7:0] wdt_ctrl_reset = 8'h53;
  localparam int unsigned wdt_base_exp = 8;
  localparam logic [1:0] slow_delay_ticks = 2'h2;

  // interrupt event bits
  localparam int unsigned irq_width = 5;
  localparam int unsigned irq_por_bit = 0;
  localparam int unsigned irq_lvr_bit = 1;
  localparam int unsigned irq_wdt_run_bit = 2;
  localparam int unsigned irq_wdt_halt_bit = 3;
  localparam int unsigned irq_wdt_reg_bit = 4;

  // special-function register table indices
  localparam logic [2:0] sfr_pc_low = 3'h0;
  localparam logic [2:0] sfr_status = 3'h1;
  localparam logic [2:0] sfr_mode = 3'h2;
  localparam logic [2:0] sfr_int_ctrl0 = 3'h3;
  localparam logic [2:0] sfr_port_a = 3'h4;
  localparam logic [2:0] sfr_port_a_dir = 3'h5;
  localparam logic [2:0] sfr_wdt_ctrl = 3'h6;
  localparam logic [2:0] sfr_time_base = 3'h7;

  // per-register reset values and keep masks
  localparam logic [7:0] zero_reset = 8'h00;
  localparam logic [7:0] mode_reset = 8'hc2;
  localparam logic [7:0] port_reset = 8'hff;
  localparam logic [7:0] time_base_reset = 8'h37;
  localparam logic [7:0] status_wdt_run_value = 8'h20;
  localparam logic [7:0] status_wdt_halt_value = 8'h30;
  localparam logic [7:0] keep_all = 8'hff;
  localparam logic [7:0] keep_none = 8'h00;
  localparam logic [7:0] status_wdt_run_keep = 8'h1f;
  localparam logic [7:0] status_wdt_halt_keep = 8'h0f;

  typedef enum logic [2:0] {
    cause_none = 3'h0,
    cause_por = 3'h1,
    cause_lvr = 3'h2,
    cause_wdt_run = 3'h3,
    cause_wdt_halt = 3'h4,
    cause_wdt_reg = 3'h5
  } cause_type;

  typedef enum logic [1:0] {
    st_run = 2'b00,
    st_wait1 = 2'b01,
    st_wait2 = 2'b11,
    st_wait3 = 2'b10
  } delay_state_type;

  typedef struct packed {
    logic pc_zero;
    logic sp_top;
    logic sp_zero;
    logic int_off;
    logic timer_off;
    logic io_input;
    logic wdt_clear;
    logic sfr_load;
  } reset_effects_type;

  typedef struct packed {
    logic [7:0] value;
    logic [7:0] keep;
  } sfr_init_type;

endpackage : reset_cause_pkg

// file: tb/reset_cause_chk.sv
// concurrent checks on the ports of the reset-cause initialiser
module reset_cause_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] rdata_q,
  // core side
  input wire reset_cause_pkg::reset_effects_type effects_q,
  input wire reset_cause_pkg::cause_type cause_q,
  input wire logic irq_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  //////////////////////////////////////////////////////////////////////
  chk_halt_effects:
    assert property (effects_q.sp_zero |-> effects_q == 8'ha0 &&
      cause_q == reset_cause_pkg::cause_wdt_halt) else $error("halt wakeup effects wrong");
  chk_full_effects:
    assert property (effects_q.sfr_load |-> effects_q == 8'hdf) else $error("full effects wrong");
  chk_full_cause:
    assert property (effects_q.sfr_load |-> cause_q inside {reset_cause_pkg::cause_por,
      reset_cause_pkg::cause_lvr, reset_cause_pkg::cause_wdt_run,
      reset_cause_pkg::cause_wdt_reg}) else $error("full reset with wrong cause");
  chk_effects_pulse:
    assert property (effects_q != 8'h00 |=> effects_q == 8'h00) else $error("effects too long");
  chk_cause_effect:
    assert property ($changed(cause_q) && cause_q != reset_cause_pkg::cause_none |->
      effects_q != 8'h00) else $error("cause changed without effects");
  chk_irq_off:
    assert property (effects_q.int_off |-> ##2 !irq_q) else $error("interrupt after full reset");
  chk_status_fields:
    assert property (reg_rd && reg_addr == reset_cause_pkg::addr_status |=>
      rdata_q[7:6] == 2'b00 && rdata_q[3:0] == 4'h0) else $error("status spare bits set");
  chk_mode_fields:
    assert property (reg_rd && reg_addr == reset_cause_pkg::addr_mode2 |=>
      (rdata_q & 8'h7a) == 8'h00) else $error("mode spare bits set");
  chk_unmapped_zero:
    assert property (reg_rd && (reg_addr == reset_cause_pkg::addr_irq_clear ||
      reg_addr > reset_cause_pkg::addr_irq_enable) |=> rdata_q == 8'h00)
      else $error("unmapped read not zero");
  chk_rdata_hold:
    assert property (!reg_rd |=> $stable(rdata_q)) else $error("read data moved");
  cov_halt: cover property (effects_q == 8'ha0);
  cov_lvr: cover property (cause_q == reset_cause_pkg::cause_lvr);
  cov_bad_code: cover property (cause_q == reset_cause_pkg::cause_wdt_reg);
  cov_irq: cover property (irq_q);
endmodule : reset_cause_chk

bind reset_cause_initialiser reset_cause_chk u_chk (.clk(clk), .rst_b(rst_b),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .rdata_q(rdata_q), .effects_q(effects_q),
  .cause_q(cause_q), .irq_q(irq_q));

// file: tb/core_model.sv
// processor-core model replaying the per-cause reset table into its register image
module core_model (
  // clock
  input wire logic clk,
  // initialiser side
  input wire reset_cause_pkg::reset_effects_type effects_q,
  input wire reset_cause_pkg::sfr_init_type sfr_init_q,
  output logic [2:0] sfr_index,
  // register image, index 0 in the top byte
  output logic [63:0] image
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] step_q;
  logic [7:0] img_q [8];
  initial begin
    step_q = 4'h0;
    sfr_index = 3'h0;
    // arbitrary old contents, so kept bits stay visible
    foreach (img_q[i]) begin
      img_q[i] = 8'h5a;
    end
  end
  assign image = {img_q[0], img_q[1], img_q[2], img_q[3], img_q[4], img_q[5], img_q[6], img_q[7]};
  //////////////////////////////////////////////////////////////////////
  // the table answers a cycle after the index, so capture lags the index by one step
  always @(posedge clk) begin
    if (effects_q != 8'h00) begin
      step_q <= 4'h1;
      sfr_index <= 3'h0;
    end else if (step_q != 4'h0 && step_q < 4'ha) begin
      step_q <= step_q + 4'h1;
      sfr_index <= sfr_index + 3'h1;
      if (step_q >= 4'h2) begin
        img_q[3'(step_q - 4'h2)] <= (img_q[3'(step_q - 4'h2)] & sfr_init_q.keep) |
          (sfr_init_q.value & ~sfr_init_q.keep);
      end
    end
  end
endmodule : core_model

// file: tb/tb_reset_cause_initialiser.sv
// self-checking bench for the reset-cause initialiser
module tb_reset_cause_initialiser;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] a_st = reset_cause_pkg::addr_status;
  localparam logic [3:0] a_wd = reset_cause_pkg::addr_wdt_ctrl;
  localparam logic [3:0] a_md = reset_cause_pkg::addr_mode2;
  localparam logic [3:0] a_is = reset_cause_pkg::addr_irq_status;
  localparam logic [3:0] a_ic = reset_cause_pkg::addr_irq_clear;
  localparam logic [3:0] a_ie = reset_cause_pkg::addr_irq_enable;
  logic clk, rst_b, reg_wr, reg_rd, core_halt, wdt_clear_cmd, low_speed_internal_oscillator_clk_in, lvr_detect_in;
  logic irq_q, rd_seen;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, rdata_q, low_speed_internal_oscillator_half, rnd;
  logic [2:0] sfr_index;
  logic [63:0] image;
  reset_cause_pkg::reset_effects_type effects_q;
  reset_cause_pkg::cause_type cause_q;
  reset_cause_pkg::sfr_init_type sfr_init_q;
  logic [7:0] rd_note[$];
  logic [7:0] eff_note[$];
  int n_mismatch, check_count, wait_n;

  reset_cause_initialiser dut (
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .rdata_q(rdata_q), .core_halt(core_halt), .wdt_clear_cmd(wdt_clear_cmd),
    .sfr_index(sfr_index), .effects_q(effects_q), .cause_q(cause_q), .sfr_init_q(sfr_init_q),
    .low_speed_internal_oscillator_clk_in(low_speed_internal_oscillator_clk_in), .lvr_detect_in(lvr_detect_in), .irq_q(irq_q));
  core_model u_core (.clk(clk), .effects_q(effects_q), .sfr_init_q(sfr_init_q),
    .sfr_index(sfr_index), .image(image));
  //////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic print_verdict();
    if (n_mismatch == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict

  // an idle cycle after each strobe keeps two drives of one strobe out of one time step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    rd_note.push_back(exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask : rd

  // waits for a cause, then lets the core model finish its table walk
  task automatic wait_cause(input reset_cause_pkg::cause_type c, input int lim);
    wait_n = 0;
    while (cause_q !== c && wait_n < lim) begin
      @(posedge clk);
      wait_n++;
    end
    check("cause_q", cause_q, c);
    repeat (12) @(posedge clk);
  endtask : wait_cause
  //////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (rd_seen)
      check("rdata_q", rdata_q, rd_note.pop_front());
    if (effects_q != 8'h00)
      check("effects_q", effects_q, eff_note.pop_front());
    rd_seen <= reg_rd;
  end

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    low_speed_internal_oscillator_clk_in = 1'b0;
    wait (rst_b === 1'b1);
    forever begin
      repeat (low_speed_internal_oscillator_half) @(posedge clk);
      low_speed_internal_oscillator_clk_in <= ~low_speed_internal_oscillator_clk_in;
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end
  //////////////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rd_seen = 1'b0;
    core_halt = 1'b0;
    wdt_clear_cmd = 1'b0;
    lvr_detect_in = 1'b0;
    void'($urandom(70));
    low_speed_internal_oscillator_half = 8'($urandom_range(3, 2));
    eff_note.push_back(8'hdf);
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    wait_cause(reset_cause_pkg::cause_por, 20);
    check("por image", image, 64'h0000c200ffff5337);
    rd(a_st, 8'h00);
    rd(a_wd, 8'h53);
    rd(a_md, 8'h00);
    rd(a_is, 8'h01);
    rd(4'hf, 8'h00);
    rd(a_ic, 8'h00);
    wr(a_st, 8'hff);
    rd(a_st, 8'h00);
    rnd = 8'($urandom()) | 8'h01;
    wr(a_ie, rnd);
    rd(a_ie, rnd & 8'h1f);
    check("irq_q", irq_q, 1'b1);
    wr(a_ie, 8'h00);
    repeat (2) @(posedge clk);
    check("irq_q", irq_q, 1'b0);
    wr(a_ie, 8'h01);
    wr(a_ic, 8'h01);
    repeat (2) @(posedge clk);
    check("irq_q", irq_q, 1'b0);
    rd(a_is, 8'h00);
    // normal watchdog with power-down already set
    wr(a_wd, 8'h50);
    wr(a_ie, 8'h1f);
    core_halt <= 1'b1;
    @(posedge clk);
    core_halt <= 1'b0;
    rd(a_st, 8'h10);
    eff_note.push_back(8'hdf);
    wait_cause(reset_cause_pkg::cause_wdt_run, 3000);
    rd(a_st, 8'h30);
    rd(a_wd, 8'h53);
    rd(a_is, 8'h04);
    rd(a_ie, 8'h00);
    check("irq_q", irq_q, 1'b0);
    check("run image", image, 64'h0020c200ffff5337);
    // watchdog expiry while halted
    wr(a_wd, 8'h50);
    wr(a_ie, 8'h08);
    core_halt <= 1'b1;
    eff_note.push_back(8'ha0);
    wait_cause(reset_cause_pkg::cause_wdt_halt, 3000);
    rd(a_st, 8'h30);
    rd(a_wd, 8'h50);
    rd(a_ie, 8'h08);
    check("irq_q", irq_q, 1'b1);
    check("halt image", image, 64'h0030c200ffff5337);
    wr(a_ic, 8'h0c);
    // low-voltage reset
    core_halt <= 1'b0;
    lvr_detect_in <= 1'b1;
    eff_note.push_back(8'hdf);
    wait_cause(reset_cause_pkg::cause_lvr, 100);
    lvr_detect_in <= 1'b0;
    rd(a_st, 8'h30);
    rd(a_md, 8'h04);
    wr(a_md, 8'h81);
    rd(a_md, 8'h80);
    wr(a_md, 8'h04);
    rd(a_md, 8'h00);
    check("lvr image", image, 64'h0030c200ffff5337);
    wdt_clear_cmd <= 1'b1;
    @(posedge clk);
    wdt_clear_cmd <= 1'b0;
    rd(a_st, 8'h00);
    // bad enable code
    eff_note.push_back(8'hdf);
    wr(a_wd, 8'h00);
    wait_cause(reset_cause_pkg::cause_wdt_reg, 60);
    check("bad code delay", 64'(wait_n >= 4 * low_speed_internal_oscillator_half && wait_n <= 6 * low_speed_internal_oscillator_half + 3), 1);
    rd(a_md, 8'h01);
    rd(a_st, 8'h00);
    rd(a_wd, 8'h53);
    // a low supply while halted is ignored
    core_halt <= 1'b1;
    lvr_detect_in <= 1'b1;
    repeat (40) @(posedge clk);
    check("cause_q", cause_q, reset_cause_pkg::cause_wdt_reg);
    print_verdict();
  end
endmodule : tb_reset_cause_initialiser
